// ===== ats_params.svh
/*
 * Constants of the transfer switch supervisor: register offsets,
 * field positions, reset values and timing figures.
 * Assumes inclusion by bare name from the design only.
 */
`ifndef ATS_PARAMS_SVH
`define ATS_PARAMS_SVH

// Clock and timing
`define ATS_CLK_HZ 40000000
`define ATS_FB_TIMEOUT_MS 3000
`define ATS_MS_CYC (`ATS_CLK_HZ / 1000)
`define ATS_FB_TIMEOUT_CYC ((`ATS_CLK_HZ / 1000) * `ATS_FB_TIMEOUT_MS)

// Register byte offsets
`define ATS_OFS_CONTROL 8'h00
`define ATS_OFS_DEAD_BAND 8'h04
`define ATS_OFS_STATUS 8'h08
`define ATS_OFS_EVENT_LOG 8'h0C

// Control fields
`define ATS_CTL_TARGET_LO 0
`define ATS_CTL_TARGET_HI 1
`define ATS_CTL_GEN_RUN 2
`define ATS_CTL_EXTENDED 3
`define ATS_CTL_DB_12 4
`define ATS_CTL_DB_21 5
`define ATS_CTL_SEC_LOAD 6
`define ATS_CTL_POL_ALARM2 7
`define ATS_CTL_POL_LOAD 8
`define ATS_CTL_FUNC_ALARM2 9
`define ATS_CTL_WIDTH 10
`define ATS_CTL_RESET 10'h000

// Dead band reset value in milliseconds
`define ATS_DEAD_BAND_RESET 16'h0000

`endif

// ===== ats_pkg.sv
/*
 * Types of the transfer switch supervisor.
 * Assumes ats_params.svh holds the numeric constants.
 */
package ats_pkg;
  // Sequencer steps
  typedef enum logic [2:0] {
    ST_IDLE, ST_OPEN_TWO, ST_OPEN_ONE, ST_DEAD, ST_CLOSE_ONE, ST_CLOSE_TWO
  } ats_step_t;

  // Switch positions
  typedef enum logic [1:0] {POS_O, POS_I, POS_II, POS_NONE} ats_pos_t;
endpackage

// ===== ats_supervisor.sv
/*
 * Transfer switch supervisor: drives the two change-over commands,
 * supervises auxiliary feedback, alarm and OK relays, generator relay,
 * Manual/Auto mode and keypad commands; registers over AHB-Lite.
 * Assumes asynchronous pins and keys, debounced outside; one AHB master.
 */
// Local design decisions: the address map and the AHB-Lite slave port.
// Behaviour
// (RULE1) Command fails without feedback within 3 s
// (RULE2) Failed command raises alarm relay and LED
// (RULE3) Auto key clears alarm, stays Manual
// (RULE4) Same supervision for secondary line switching
// (RULE5) Extended: second alarm output and log entry
// (RULE6) Bistable relay starts and stops generator
// (RULE7) Alarm contact closed when disabled or alarmed
// (RULE8) Status inputs active when switch closed
// (RULE9) Handle present forces Manual, no switching
// (RULE10) Auto needs handle released then Auto key
// (RULE11) Extended: programmable output function and polarity; the code also applies the load polarity in basic variants
// (RULE12) Basic variants transfer without pausing open
// (RULE13) Extended pauses open when dead band enabled; the code pauses in Auto mode only
// (RULE14) Auto key toggles Auto and Manual modes
// (RULE15) Auto refused with selector in test/setup
// (RULE16) Key I closes one; no effect if closed
// (RULE17) Key O opens switch one, two stays open
// (RULE18) Key II closes two, one stays open
// (RULE19) Open switch two before closing switch one
// (RULE20) Open command overrides simultaneous I or II
// (RULE21) Manual generator control only in extended variant
// (RULE22) Timeout counter restarts per command step
`include "ats_params.svh"
module ats_supervisor import ats_pkg::*; #(
  parameter int unsigned TIMEOUT_CYCLES = `ATS_FB_TIMEOUT_CYC,
  parameter int unsigned MS_CYCLES = `ATS_MS_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Switch feedback and handle
  input wire logic switch_one_status_in,
  input wire logic switch_two_status_in,
  input wire logic handle_present_in,
  // Keypad and selector
  input wire logic key_one_in,
  input wire logic key_open_in,
  input wire logic key_two_in,
  input wire logic key_auto_in,
  input wire logic selector_test_setup_in,
  // Switch commands
  output logic switch_one_command_out,
  output logic switch_two_command_out,
  // Relays and indicators
  output logic generator_relay_out,
  output logic alarm_relay_out,
  output logic ok_relay_out,
  output logic second_alarm_out,
  output logic secondary_load_out,
  output logic alarm_led_out,
  output logic auto_led_out
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; stage one feeds stage two only
  logic [7:0] sync1_reg;
  logic [7:0] sync2_reg;
  logic [3:0] key_prev_reg;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sync1_reg <= 8'h00;
      sync2_reg <= 8'h00;
      key_prev_reg <= 4'h0;
    end else begin
      sync1_reg <= {selector_test_setup_in, key_auto_in, key_two_in, key_open_in,
                    key_one_in, handle_present_in, switch_two_status_in,
                    switch_one_status_in};
      sync2_reg <= sync1_reg;
      key_prev_reg <= sync2_reg[6:3];
    end
  end

  // Closed contact reads active, open reads inactive [RULE8]
  wire sw1_s = sync2_reg[0];
  wire sw2_s = sync2_reg[1];
  wire handle_s = sync2_reg[2];
  wire test_setup_s = sync2_reg[7];
  wire [3:0] key_press = sync2_reg[6:3] & ~key_prev_reg;
  wire k_one = key_press[0];
  wire k_open = key_press[1];
  wire k_two = key_press[2];
  wire k_auto = key_press[3];

  ////////////////////////////////////////////////////////////////////////
  // Registers and mode state
  logic [`ATS_CTL_WIDTH-1:0] ctl_reg;
  logic [15:0] dead_ms_reg;
  logic auto_mode_reg, auto_mode_next;
  logic fail_alarm_reg, fail_alarm_next;
  logic [7:0] fail_count_reg;
  logic [2:0] last_step_reg;
  ats_step_t step_reg, step_next;
  ats_pos_t goal_reg, goal_next;
  logic [31:0] fb_timer_reg;
  logic [31:0] ms_pre_reg;
  logic [15:0] dead_cnt_reg;

  wire extended = ctl_reg[`ATS_CTL_EXTENDED];
  wire [1:0] auto_target = ctl_reg[`ATS_CTL_TARGET_HI:`ATS_CTL_TARGET_LO];

  ////////////////////////////////////////////////////////////////////////
  // Step decode
  wire cmd_step = (step_reg != ST_IDLE) && (step_reg != ST_DEAD);
  wire open_step = (step_reg == ST_OPEN_ONE) || (step_reg == ST_OPEN_TWO);
  wire step_done = (step_reg == ST_OPEN_TWO) ? !sw2_s :
                   (step_reg == ST_OPEN_ONE) ? !sw1_s :
                   (step_reg == ST_CLOSE_ONE) ? sw1_s :
                   (step_reg == ST_CLOSE_TWO) ? sw2_s : 1'b0;
  // Same supervision for every command step, either line [RULE1] [RULE4]
  wire fail_event = cmd_step && !step_done &&
                    (fb_timer_reg == TIMEOUT_CYCLES - 1);
  // Handle or a standing alarm stops all electrical switching [RULE9]
  wire inhibit = handle_s || fail_event || fail_alarm_reg;

  // Manual keys: O wins over I and II [RULE20] [RULE17]
  wire man_req = !auto_mode_reg && (k_open || k_one || k_two);
  wire [1:0] man_pos = k_open ? 2'd0 : (k_one ? 2'd1 : 2'd2);
  wire auto_req = auto_mode_reg && (auto_target != 2'd3);
  wire req_go = man_req || auto_req;
  wire [1:0] req_pos = auto_mode_reg ? auto_target : man_pos;

  // Dead band only in extended variant, per direction [RULE12] [RULE13]
  wire dead_en = auto_mode_reg && extended && (dead_ms_reg != 16'h0000) &&
                 ((goal_reg == POS_I) ? ctl_reg[`ATS_CTL_DB_21] :
                  (goal_reg == POS_II) ? ctl_reg[`ATS_CTL_DB_12] : 1'b0);
  wire ms_tick = (ms_pre_reg == MS_CYCLES - 1);
  wire dead_over = (dead_cnt_reg >= dead_ms_reg);

  // First step toward a goal; break before make [RULE16] [RULE18] [RULE19]
  function automatic ats_step_t first_step(input ats_pos_t goal, input logic s1,
                                           input logic s2);
    ats_step_t st;
    st = ST_IDLE;
    case (goal)
      POS_I: st = s2 ? ST_OPEN_TWO : (!s1 ? ST_CLOSE_ONE : ST_IDLE);
      POS_II: st = s1 ? ST_OPEN_ONE : (!s2 ? ST_CLOSE_TWO : ST_IDLE);
      POS_O: st = s1 ? ST_OPEN_ONE : (s2 ? ST_OPEN_TWO : ST_IDLE);
      default: st = ST_IDLE;
    endcase
    return st;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Sequencer next state
  always_comb begin
    step_next = step_reg;
    goal_next = goal_reg;
    if (inhibit) begin
      step_next = ST_IDLE;
    end else begin
      case (step_reg)
        ST_IDLE: begin
          if (req_go) begin
            goal_next = ats_pos_t'(req_pos);
            step_next = first_step(ats_pos_t'(req_pos), sw1_s, sw2_s);
          end
        end
        ST_DEAD: begin
          if (dead_over) begin
            step_next = first_step(goal_reg, sw1_s, sw2_s);
          end
        end
        default: begin
          if (step_done) begin
            if (open_step && goal_reg != POS_O && dead_en) begin
              step_next = ST_DEAD;
            end else begin
              step_next = first_step(goal_reg, sw1_s, sw2_s);
            end
          end
        end
      endcase
    end
  end

  // Mode: handle first, then failures, then the Auto key
  always_comb begin
    auto_mode_next = auto_mode_reg;
    fail_alarm_next = fail_alarm_reg;
    if (handle_s || fail_event) begin
      auto_mode_next = 1'b0; // [RULE9] [RULE10]
    end else if (k_auto) begin
      if (fail_alarm_reg) begin
        auto_mode_next = 1'b0; // [RULE3]
      end else if (auto_mode_reg) begin
        auto_mode_next = 1'b0; // [RULE14]
      end else if (!test_setup_s) begin
        auto_mode_next = 1'b1; // [RULE14] [RULE15]
      end
    end
    // Set wins over the clearing key press [RULE2] [RULE3]
    if (fail_event) begin
      fail_alarm_next = 1'b1;
    end else if (k_auto) begin
      fail_alarm_next = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer, mode and timers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      step_reg <= ST_IDLE;
      goal_reg <= POS_O;
      auto_mode_reg <= 1'b0;
      fail_alarm_reg <= 1'b0;
    end else begin
      step_reg <= step_next;
      goal_reg <= goal_next;
      auto_mode_reg <= auto_mode_next;
      fail_alarm_reg <= fail_alarm_next;
    end
  end

  // Restart on every new step, hold at zero outside command steps [RULE22]
  always_ff @(posedge sys_clk) begin
    if (!rst_n || step_next != step_reg || !cmd_step) begin
      fb_timer_reg <= 32'h0000_0000;
    end else if (fb_timer_reg != TIMEOUT_CYCLES - 1) begin
      fb_timer_reg <= fb_timer_reg + 32'h0000_0001; // [RULE1]
    end
  end

  // Millisecond prescaler and dead band count
  always_ff @(posedge sys_clk) begin
    if (!rst_n || step_reg != ST_DEAD) begin
      ms_pre_reg <= 32'h0000_0000;
      dead_cnt_reg <= 16'h0000;
    end else if (ms_tick) begin
      ms_pre_reg <= 32'h0000_0000;
      dead_cnt_reg <= dead_cnt_reg + 16'h0001; // [RULE13]
    end else begin
      ms_pre_reg <= ms_pre_reg + 32'h0000_0001;
    end
  end

  // Event log: count and step of each failure, extended only
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      fail_count_reg <= 8'h00;
      last_step_reg <= 3'h0;
    end else if (fail_event && extended) begin
      fail_count_reg <= fail_count_reg + 8'h01; // [RULE5]
      last_step_reg <= step_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output relays and commands, all registered
  wire one_cmd_next = !inhibit &&
                      (step_next == ST_OPEN_TWO || step_next == ST_CLOSE_ONE);
  wire two_cmd_next = !inhibit &&
                      (step_next == ST_OPEN_ONE || step_next == ST_CLOSE_TWO);
  // Alarm contact closes when disabled or alarmed [RULE7]
  wire alarm_next = !(auto_mode_next && !fail_alarm_next);
  // Function: failed command or Manual indication, then polarity [RULE11]
  wire alarm2_fn = ctl_reg[`ATS_CTL_FUNC_ALARM2] ? !auto_mode_next : fail_alarm_next;
  wire alarm2_next = extended && (alarm2_fn ^ ctl_reg[`ATS_CTL_POL_ALARM2]); // [RULE5]
  wire load_next = ctl_reg[`ATS_CTL_SEC_LOAD] ^ ctl_reg[`ATS_CTL_POL_LOAD]; // [RULE11]
  // Generator frozen in Manual for basic variants [RULE21]
  wire gen_allow = auto_mode_reg || extended;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      switch_one_command_out <= 1'b0;
      switch_two_command_out <= 1'b0;
      generator_relay_out <= 1'b0;
      alarm_relay_out <= 1'b1;
      ok_relay_out <= 1'b0;
      second_alarm_out <= 1'b0;
      secondary_load_out <= 1'b0;
      alarm_led_out <= 1'b0;
      auto_led_out <= 1'b0;
    end else begin
      switch_one_command_out <= one_cmd_next; // [RULE19]
      switch_two_command_out <= two_cmd_next;
      if (gen_allow) begin
        generator_relay_out <= ctl_reg[`ATS_CTL_GEN_RUN]; // [RULE6]
      end
      alarm_relay_out <= alarm_next;
      ok_relay_out <= !alarm_next; // [RULE7]
      second_alarm_out <= alarm2_next;
      secondary_load_out <= load_next;
      alarm_led_out <= fail_alarm_next; // [RULE2]
      auto_led_out <= auto_mode_next; // [RULE10]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave, zero wait states, always OKAY
  logic dp_write_reg;
  logic [7:0] dp_addr_reg;
  wire ap_valid = hsel && htrans[1] && hready;
  wire [31:0] status_word = {24'h00_0000, goal_reg, step_reg != ST_IDLE,
                             handle_s, sw2_s, sw1_s, fail_alarm_reg, auto_mode_reg};
  wire [31:0] read_word = (haddr == `ATS_OFS_CONTROL) ? {22'h00_0000, ctl_reg} :
                          (haddr == `ATS_OFS_DEAD_BAND) ? {16'h0000, dead_ms_reg} :
                          (haddr == `ATS_OFS_STATUS) ? status_word :
                          (haddr == `ATS_OFS_EVENT_LOG) ?
                          {21'h00_0000, last_step_reg, fail_count_reg} : 32'h0000_0000;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dp_write_reg <= 1'b0;
      dp_addr_reg <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      dp_write_reg <= ap_valid && hwrite;
      dp_addr_reg <= haddr;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (ap_valid && !hwrite) begin
        hrdata <= read_word;
      end
    end
  end

  // Write data phase; status and log are read-only
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctl_reg <= `ATS_CTL_RESET;
      dead_ms_reg <= `ATS_DEAD_BAND_RESET;
    end else if (dp_write_reg && dp_addr_reg == `ATS_OFS_CONTROL) begin
      ctl_reg <= hwdata[`ATS_CTL_WIDTH-1:0];
    end else if (dp_write_reg && dp_addr_reg == `ATS_OFS_DEAD_BAND) begin
      dead_ms_reg <= hwdata[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_no_both_cmd;
    !(switch_one_command_out && switch_two_command_out);
  endproperty
  a_no_both_cmd: assert property (p_no_both_cmd) else $error("both commands on"); // [RULE19]
  property p_fail_timing;
    $rose(fail_alarm_reg) |-> $past(fb_timer_reg) == TIMEOUT_CYCLES - 1 && $past(cmd_step);
  endproperty
  a_fail_timing: assert property (p_fail_timing) else $error("alarm not at timeout"); // [RULE1]
  property p_fail_outputs;
    fail_event |=> alarm_relay_out && !ok_relay_out && alarm_led_out && !auto_led_out
                   && !switch_one_command_out && !switch_two_command_out;
  endproperty
  a_fail_outputs: assert property (p_fail_outputs) else $error("fail outputs wrong"); // [RULE2]
  property p_alarm_clear;
    fail_alarm_reg && k_auto && !fail_event |=> !fail_alarm_reg && !auto_mode_reg;
  endproperty
  a_alarm_clear: assert property (p_alarm_clear) else $error("alarm clear wrong"); // [RULE3]
  property p_ok_contact;
    ok_relay_out == (auto_led_out && !alarm_led_out);
  endproperty
  a_ok_contact: assert property (p_ok_contact) else $error("OK contact wrong"); // [RULE7]
  // Both commands drop right after the handle is seen
  property p_handle_manual;
    handle_s |=> !auto_mode_reg && step_reg == ST_IDLE && !switch_one_command_out
                 && !switch_two_command_out;
  endproperty
  a_handle_manual: assert property (p_handle_manual) else $error("handle ignored"); // [RULE9]
  property p_refuse_test;
    test_setup_s && !auto_mode_reg |=> !auto_mode_reg;
  endproperty
  a_refuse_test: assert property (p_refuse_test) else $error("auto in test"); // [RULE15]
  property p_open_prio;
    step_reg == ST_IDLE && !inhibit && man_req && k_open |=> goal_reg == POS_O;
  endproperty
  a_open_prio: assert property (p_open_prio) else $error("open not first"); // [RULE20]
  property p_gen_manual;
    !auto_mode_reg && !extended |=> $stable(generator_relay_out);
  endproperty
  a_gen_manual: assert property (p_gen_manual) else $error("generator moved"); // [RULE21]
  property p_basic_no_dead;
    !extended |-> step_reg != ST_DEAD;
  endproperty
  a_basic_no_dead: assert property (p_basic_no_dead) else $error("basic paused"); // [RULE12]
  c_fail: cover property (fail_event);
  c_enter_auto: cover property (!auto_mode_reg ##1 auto_mode_reg);
  c_dead_band: cover property (step_reg == ST_DEAD ##1 step_reg == ST_CLOSE_ONE);
  c_break_make: cover property (step_reg == ST_OPEN_TWO ##1 step_reg == ST_CLOSE_ONE);
endmodule

// ===== ats_switch_model.sv
/*
 * Partner model: motorized change-over switch with two auxiliary contacts.
 * Assumes level commands from the supervisor; travel time and a stuck
 * motor are set by the bench.
 */
module ats_switch_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Commands from the supervisor
  input wire logic switch_one_command_out,
  input wire logic switch_two_command_out,
  // Bench controls
  input wire logic [7:0] delay_cycles,
  input wire logic stuck,
  // Auxiliary contacts, high = closed
  output logic switch_one_status_in,
  output logic switch_two_status_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_reg;
  //////////////////////////////////////////////////////////////////////
  // One contact moves per travel time; a stuck motor never answers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      switch_one_status_in <= 1'b0;
      switch_two_status_in <= 1'b0;
      cnt_reg <= 8'h00;
    end else if (stuck || (switch_one_command_out == switch_two_command_out)) begin
      cnt_reg <= 8'h00;
    end else if (cnt_reg != delay_cycles) begin
      cnt_reg <= cnt_reg + 8'h01;
    end else begin
      cnt_reg <= 8'h00;
      // Closed contact reads high; II leaves before I closes
      if (switch_one_command_out) begin
        switch_two_status_in <= 1'b0;
        switch_one_status_in <= !switch_two_status_in;
      end else begin
        switch_one_status_in <= 1'b0;
        switch_two_status_in <= !switch_one_status_in;
      end
    end
  end
endmodule

// ===== transfer_switch_supervisor_tb.sv
/*
 * Self-checking bench of the transfer switch supervisor.
 * Assumes the switch model as far side and a short feedback timeout.
 */
module transfer_switch_supervisor_tb;
  import ats_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TO = 200;
  logic sys_clk = 1'b0;
  logic rst_n, hsel, hwrite, stuck, hnd, sel, k1, ko, k2, ka;
  logic [7:0] haddr, dly;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic hreadyout, hresp, sw1, sw2, cmd1, cmd2, gen, alarm, ok, alarm2, load, led_a, led_auto;
  logic cmd1_d, cmd2_d;
  logic [1:0] p;
  logic [2:0] k;
  int n_mismatch = 0;
  int tests_run = 0;
  int rises1 = 0;
  int falls2 = 0;
  int f, i;
  //////////////////////////////////////////////////////////////////////
  // Clock, design and far side
  initial forever #12.5 sys_clk = ~sys_clk;
  ats_supervisor #(.TIMEOUT_CYCLES(TO), .MS_CYCLES(4)) uut (.sys_clk(sys_clk), .rst_n(rst_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .switch_one_status_in(sw1), .switch_two_status_in(sw2),
    .handle_present_in(hnd), .key_one_in(k1), .key_open_in(ko), .key_two_in(k2),
    .key_auto_in(ka), .selector_test_setup_in(sel), .switch_one_command_out(cmd1),
    .switch_two_command_out(cmd2), .generator_relay_out(gen), .alarm_relay_out(alarm),
    .ok_relay_out(ok), .second_alarm_out(alarm2), .secondary_load_out(load),
    .alarm_led_out(led_a), .auto_led_out(led_auto));
  ats_switch_model model (.sys_clk(sys_clk), .rst_n(rst_n), .switch_one_command_out(cmd1),
    .switch_two_command_out(cmd2), .delay_cycles(dly), .stuck(stuck),
    .switch_one_status_in(sw1), .switch_two_status_in(sw2));
  //////////////////////////////////////////////////////////////////////
  // Compare tasks
  task automatic chk1(input string nm, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %0b seen %0b", nm, e, g);
    end
  endtask
  task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  // Bus, keypad and wait helpers
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    rd = hrdata;
  endtask
  // Keys held 4 cycles, longer than the 2 the sync needs
  task automatic press(input logic [3:0] kk);
    @(posedge sys_clk);
    {ka, k2, ko, k1} <= kk;
    cyc(4);
    {ka, k2, ko, k1} <= 4'h0;
    cyc(8);
  endtask
  // Idle means 16 quiet cycles, so a dead band gap is not taken as the end
  task automatic settle();
    int n;
    int q;
    n = 0;
    q = 0;
    while (q < 16 && n < 3000) begin
      @(posedge sys_clk);
      n++;
      q = (cmd1 === 1'b1 || cmd2 === 1'b1) ? 0 : q + 1;
    end
  endtask
  // Position {sw2, sw1} after keys {two, open, one}; O wins, then I
  function automatic logic [1:0] exp_pos(input logic [2:0] kk, input logic [1:0] pp);
    if (kk[1]) return 2'b00;
    if (kk[0]) return 2'b01;
    if (kk[2]) return 2'b10;
    return pp;
  endfunction
  //////////////////////////////////////////////////////////////////////
  // Monitor: never both commands, never both contacts closed
  always @(posedge sys_clk) begin
    cmd1_d <= cmd1;
    cmd2_d <= cmd2;
    if (cmd1_d === 1'b0 && cmd1 === 1'b1) rises1++;
    if (cmd2_d === 1'b1 && cmd2 === 1'b0) falls2++;
    if (rst_n === 1'b1 && (cmd1 & cmd2) !== 1'b0) chk1("both_cmds", 1'b0, cmd1 & cmd2);
    if (rst_n === 1'b1 && (sw1 & sw2) === 1'b1) chk1("both_closed", 1'b0, 1'b1);
  end
  // Watchdog far beyond the expected run
  initial begin
    cyc(40000);
    n_mismatch++;
    test_done();
  end
  //////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {rst_n, hsel, hwrite, stuck, hnd, sel, k1, ko, k2, ka} = 10'h000;
    {haddr, htrans, hwdata} = 42'h0;
    hsize = 3'b010;
    dly = 8'h0a;
    void'($urandom(79276));
    cyc(6);
    rst_n <= 1'b1;
    cyc(3);
    chk1("alarm_relay", 1'b1, alarm);
    chk1("ok_relay", 1'b0, ok);
    chk1("auto_led", 1'b0, led_auto);
    chk1("hresp", 1'b0, hresp);
    $display("test reset done");
    // Manual corner cases
    press(4'h1);
    settle();
    chk32("pos", 32'h1, {30'h0, sw2, sw1});
    f = rises1;
    press(4'h1);
    settle();
    chk32("no_effect", f, rises1);
    press(4'h4);
    settle();
    chk32("pos", 32'h2, {30'h0, sw2, sw1});
    ahb(1'b0, 8'h08, 32'h0);
    chk32("status_sw", 32'h2, {30'h0, rd[3:2]});
    chk32("status_goal", 32'h2, {30'h0, rd[7:6]});
    press(4'h1);
    settle();
    chk32("pos", 32'h1, {30'h0, sw2, sw1});
    press(4'h3);
    settle();
    chk32("pos", 32'h0, {30'h0, sw2, sw1});
    // Random keys and travel times
    for (i = 0; i < 12; i++) begin
      k = 3'($urandom_range(1, 7));
      dly <= 8'($urandom_range(5, 40));
      p = exp_pos(k, {sw2, sw1});
      press({1'b0, k});
      settle();
      chk32("pos", {30'h0, p}, {30'h0, sw2, sw1});
    end
    ahb(1'b0, 8'h20, 32'h0);
    chk32("unmapped", 32'h0, rd);
    $display("test manual done");
    // Mode changes
    ahb(1'b1, 8'h00, 32'h3);
    sel <= 1'b1;
    press(4'h8);
    chk1("auto_led", 1'b0, led_auto);
    sel <= 1'b0;
    press(4'h8);
    chk1("auto_led", 1'b1, led_auto);
    chk1("alarm_relay", 1'b0, alarm);
    chk1("ok_relay", 1'b1, ok);
    press(4'h8);
    chk1("auto_led", 1'b0, led_auto);
    chk1("alarm_relay", 1'b1, alarm);
    press(4'h8);
    hnd <= 1'b1;
    cyc(5);
    chk1("auto_led", 1'b0, led_auto);
    p = {sw2, sw1};
    // Pick a key that would move the switch, so the check can trip
    press(p[0] ? 4'h4 : 4'h1);
    settle();
    chk32("pos", {30'h0, p}, {30'h0, sw2, sw1});
    press(4'h8);
    chk1("auto_led", 1'b0, led_auto);
    hnd <= 1'b0;
    cyc(5);
    chk1("auto_led", 1'b0, led_auto);
    press(4'h8);
    chk1("auto_led", 1'b1, led_auto);
    $display("test mode done");
    // Generator and automatic transfers
    ahb(1'b1, 8'h00, 32'h7);
    cyc(3);
    chk1("gen", 1'b1, gen);
    ahb(1'b1, 8'h00, 32'h1);
    settle();
    chk1("gen", 1'b0, gen);
    f = falls2;
    ahb(1'b1, 8'h00, 32'h2);
    settle();
    chk32("pos", 32'h2, {30'h0, sw2, sw1});
    chk32("two_cmd_gaps", f + 1, falls2);
    ahb(1'b1, 8'h00, 32'h1);
    settle();
    ahb(1'b1, 8'h04, 32'h2);
    f = falls2;
    ahb(1'b1, 8'h00, 32'h1a);
    settle();
    chk32("pos", 32'h2, {30'h0, sw2, sw1});
    chk32("two_cmd_gaps", f + 2, falls2);
    press(4'h8);
    ahb(1'b1, 8'h00, 32'hf);
    cyc(3);
    chk1("gen", 1'b1, gen);
    ahb(1'b1, 8'h00, 32'h3);
    cyc(3);
    chk1("gen", 1'b1, gen);
    $display("test transfer done");
    // Failed back switching, extended variant; then load output, basic variant
    ahb(1'b1, 8'h00, 32'hb);
    press(4'h8);
    stuck <= 1'b1;
    ahb(1'b1, 8'h00, 32'h9);
    i = 0;
    while (cmd1 !== 1'b1 && i < 50) begin
      @(posedge sys_clk);
      i++;
    end
    cyc(TO - 10);
    chk1("cmd1", 1'b1, cmd1);
    chk1("alarm_led", 1'b0, led_a);
    cyc(20);
    chk1("alarm_led", 1'b1, led_a);
    chk1("alarm_relay", 1'b1, alarm);
    chk1("ok_relay", 1'b0, ok);
    chk1("alarm2", 1'b1, alarm2);
    chk1("cmd1", 1'b0, cmd1);
    ahb(1'b0, 8'h0c, 32'h0);
    chk32("fail_count", 32'h1, {24'h0, rd[7:0]});
    stuck <= 1'b0;
    press(4'h8);
    chk1("alarm_led", 1'b0, led_a);
    chk1("auto_led", 1'b0, led_auto);
    press(4'h8);
    chk1("auto_led", 1'b1, led_auto);
    settle();
    ahb(1'b1, 8'h00, 32'h43);
    cyc(3);
    chk1("load", 1'b1, load);
    ahb(1'b1, 8'h00, 32'h143);
    cyc(3);
    chk1("load", 1'b0, load);
    // Second alarm as Manual indicator, then inverted
    ahb(1'b1, 8'h00, 32'h20b);
    cyc(3);
    chk1("alarm2", 1'b0, alarm2);
    press(4'h8);
    chk1("alarm2", 1'b1, alarm2);
    ahb(1'b1, 8'h00, 32'h28b);
    cyc(3);
    chk1("alarm2", 1'b0, alarm2);
    $display("test failure done");
    test_done();
  end
endmodule
